// ---- inc/pdcr_pkg.sv ----
package pdcr_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] FB_HI_OFS   = 8'h28;
    localparam logic [7:0] FB_MID_OFS  = 8'h29;
    localparam logic [7:0] FB_LO_OFS   = 8'h2A;
    localparam logic [7:0] IN1_HI_OFS  = 8'h2B;
    localparam logic [7:0] IN1_MID_OFS = 8'h2C;
    localparam logic [7:0] IN1_LO_OFS  = 8'h2D;
    localparam logic [7:0] IN2_HI_OFS  = 8'h2E;
    localparam logic [7:0] IN2_MID_OFS = 8'h2F;
    localparam logic [7:0] IN2_LO_OFS  = 8'h30;
    localparam logic [7:0] IN3_HI_OFS  = 8'h31;
    localparam logic [7:0] IN3_MID_OFS = 8'h32;
    localparam logic [7:0] IN3_LO_OFS  = 8'h33;
    localparam logic [7:0] IN4_HI_OFS  = 8'h34;
    localparam logic [7:0] IN4_MID_OFS = 8'h35;
    localparam logic [7:0] IN4_LO_OFS  = 8'h36;

    localparam int NUM_REGS   = 15;
    localparam int NUM_INPUTS = 4;
    localparam int IDX_W      = 4;
    localparam int PREDIV_W   = 19;
    localparam int FB_LS_W    = 20;

    // ----------------------------------------------------------------
    // Register indices and field positions
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] FB_HI_IDX  = 4'h0;
    localparam logic [IDX_W-1:0] FB_MID_IDX = 4'h1;
    localparam logic [IDX_W-1:0] FB_LO_IDX  = 4'h2;
    localparam int PREDIV_IDX0 = 3;
    localparam int FB_HS_MSB   = 7;
    localparam int FB_HS_LSB   = 5;
    localparam int FB_RSV_BIT  = 4;
    localparam int FB_TOP_MSB  = 3;
    localparam int PD_TOP_MSB  = 2;
    localparam logic [3:0] FB_HS_BASE = 4'h4;

    // ----------------------------------------------------------------
    // Writable masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] FB_HI_WMASK = 8'hEF;
    localparam logic [7:0] PD_HI_WMASK = 8'h07;
    localparam logic [7:0] FULL_WMASK  = 8'hFF;

    localparam logic [7:0] FB_HI_RST  = 8'hC0;
    localparam logic [7:0] FB_MID_RST = 8'h00;
    localparam logic [7:0] FB_LO_RST  = 8'hF9;
    localparam logic [7:0] PD_HI_RST  = 8'h00;
    localparam logic [7:0] PD_MID_RST = 8'h00;
    localparam logic [7:0] PD_LO_RST  = 8'h09;
    localparam logic [7:0] PD_LO2_RST = 8'h00;

    localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {
        FULL_WMASK, FULL_WMASK, PD_HI_WMASK, FULL_WMASK, FULL_WMASK, PD_HI_WMASK,
        FULL_WMASK, FULL_WMASK, PD_HI_WMASK, FULL_WMASK, FULL_WMASK, PD_HI_WMASK,
        FULL_WMASK, FULL_WMASK, FB_HI_WMASK};

    localparam logic [NUM_REGS-1:0][7:0] REG_RST = {
        PD_LO2_RST, PD_MID_RST, PD_HI_RST, PD_LO_RST, PD_MID_RST, PD_HI_RST,
        PD_LO2_RST, PD_MID_RST, PD_HI_RST, PD_LO_RST, PD_MID_RST, PD_HI_RST,
        FB_LO_RST, FB_MID_RST, FB_HI_RST};

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdcr_req_t;

    typedef struct packed {
        logic [2:0]                            fb_hs_code;
        logic [3:0]                            fb_hs_ratio;
        logic [FB_LS_W-1:0]                    fb_ls;
        logic [NUM_INPUTS-1:0][PREDIV_W-1:0]   prediv;
    } pdcr_cfg_t;

endpackage

// ---- core/pdcr_byte_reg.sv ----
`timescale 1ns/1ps
module pdcr_byte_reg
    import pdcr_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hFF,
    parameter logic [7:0] RST   = 8'h00
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);

    logic [7:0] val_ff;

    // Reserved bits are never stored, so they read zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            val_ff <= RST & WMASK;
        end else if (we_i) begin
            val_ff <= wdata_i & WMASK;
        end
    end

    assign q_o = val_ff;

endmodule

// ---- core/pdcr_read_port.sv ----
`timescale 1ns/1ps
module pdcr_read_port
    import pdcr_pkg::*;
#(
    parameter int NUM = NUM_REGS
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  rd_i,
    input  wire logic                  hit_i,
    input  wire logic [IDX_W-1:0]      idx_i,
    input  wire logic [NUM-1:0][7:0]   regs_i,
    output logic                       ack_o,
    output logic      [7:0]            rdata_o
);

    logic       ack_ff;
    logic [7:0] rdata_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= rd_i;
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_i) begin
            rdata_ff <= (hit_i && (int'(idx_i) < NUM)) ? regs_i[idx_i] : 8'h00;
        end
    end

    assign ack_o   = ack_ff;
    assign rdata_o = rdata_ff;

endmodule

// ---- core/pdcr_regs.sv ----
`timescale 1ns/1ps
// Function
// [RULE1] High-speed feedback code in bits 7:5; codes 0..7 divide by 4..11.
// [RULE2] Feedback low-speed divider is 20 bits: top nibble, middle byte, low byte.
// [RULE3] Feedback registers reset to C0, 00 and F9.
// [RULE4] Input 1 pre-divider: 19 bits, upper three bits in low bits of hi register.
// [RULE5] Input 2 pre-divider: same hi, mid, lo split.
// [RULE6] Input 3 pre-divider: only low three bits of hi register writable.
// [RULE7] Input 4 pre-divider: upper three bits in low bits of its first register.
// [RULE8] Inputs 1 and 3 pre-divider low bytes reset to 09, hi registers zero.
// [RULE9] Bit 4 of feedback hi and bits 7:3 of pre-divider hi are read-only.
// [RULE10] Read-only bits read zero and ignore writes, sparing neighbouring fields.
// [RULE11] Host writes every byte of a divider before relying on the new ratio.
module pdcr_regs
    import pdcr_pkg::*;
#(
    parameter int N_INPUTS = NUM_INPUTS,
    parameter int PD_W     = PREDIV_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire pdcr_req_t  req_i,
    output logic            ack_o,
    output logic      [7:0] rdata_o,
    output pdcr_cfg_t       cfg_o
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (N_INPUTS != NUM_INPUTS) begin : g_bad_inputs
        $error("Register map serves exactly four inputs");
    end
    if (PD_W != PREDIV_W) begin : g_bad_width
        $error("Pre-divider width is fixed by the byte split");
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr >= FB_HI_OFS) && (addr <= IN4_LO_OFS);
    endfunction

    function automatic logic [IDX_W-1:0] reg_idx(input logic [7:0] addr);
        logic [7:0] diff;
        diff    = addr - FB_HI_OFS;
        reg_idx = diff[IDX_W-1:0];
    endfunction

    logic                     wr_hit;
    logic                     rd_hit;
    logic [IDX_W-1:0]         wr_idx;
    logic [IDX_W-1:0]         rd_idx;
    logic [NUM_REGS-1:0][7:0] regs_w;

    assign wr_hit = req_i.wr && reg_hit(req_i.addr);
    assign rd_hit = reg_hit(req_i.addr);
    assign wr_idx = reg_idx(req_i.addr);
    assign rd_idx = reg_idx(req_i.addr);

    // ----------------------------------------------------------------
    // Register cells
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        pdcr_byte_reg #(
            .WMASK (REG_WMASK[i]), // [RULE9]
            .RST   (REG_RST[i])
        ) u_cell (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .we_i    (wr_hit && (wr_idx == IDX_W'(i))), // [RULE10]
            .wdata_i (req_i.wdata),
            .q_o     (regs_w[i])
        );
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    pdcr_read_port #(
        .NUM (NUM_REGS)
    ) u_read (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .rd_i    (req_i.rd),
        .hit_i   (rd_hit),
        .idx_i   (rd_idx),
        .regs_i  (regs_w),
        .ack_o   (ack_o),
        .rdata_o (rdata_o)
    );

    // ----------------------------------------------------------------
    // Divider assembly
    // ----------------------------------------------------------------
    pdcr_cfg_t  nxt_cfg;
    pdcr_cfg_t  cfg_ff;
    logic [7:0] fb_hi_w;
    logic [7:0] fb_mid_w;
    logic [7:0] fb_lo_w;

    assign fb_hi_w  = regs_w[FB_HI_IDX];
    assign fb_mid_w = regs_w[FB_MID_IDX];
    assign fb_lo_w  = regs_w[FB_LO_IDX];

    always_comb begin
        nxt_cfg             = '0;
        nxt_cfg.fb_hs_code  = fb_hi_w[FB_HS_MSB:FB_HS_LSB]; // [RULE1]
        nxt_cfg.fb_hs_ratio = {1'b0, fb_hi_w[FB_HS_MSB:FB_HS_LSB]} + FB_HS_BASE; // [RULE1]
        nxt_cfg.fb_ls       = {fb_hi_w[FB_TOP_MSB:0], fb_mid_w, fb_lo_w}; // [RULE2]
        for (int k = 0; k < NUM_INPUTS; k++) begin
            // Upper three bits, middle byte, low byte per input
            nxt_cfg.prediv[k] = {regs_w[PREDIV_IDX0 + 3 * k][PD_TOP_MSB:0],
                                 regs_w[PREDIV_IDX0 + 3 * k + 1],
                                 regs_w[PREDIV_IDX0 + 3 * k + 2]}; // [RULE4] [RULE5] [RULE6] [RULE7]
        end
    end

    // Takes the new ratio one cycle after the byte lands; partial
    // updates pass straight through, the host sequences the bytes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_ff.fb_hs_code  <= FB_HI_RST[FB_HS_MSB:FB_HS_LSB]; // [RULE3]
            cfg_ff.fb_hs_ratio <= {1'b0, FB_HI_RST[FB_HS_MSB:FB_HS_LSB]} + FB_HS_BASE;
            cfg_ff.fb_ls       <= {FB_HI_RST[FB_TOP_MSB:0], FB_MID_RST, FB_LO_RST};
            for (int k = 0; k < NUM_INPUTS; k++) begin
                cfg_ff.prediv[k] <= {REG_RST[PREDIV_IDX0 + 3 * k][PD_TOP_MSB:0],
                                     REG_RST[PREDIV_IDX0 + 3 * k + 1],
                                     REG_RST[PREDIV_IDX0 + 3 * k + 2]}; // [RULE8]
            end
        end else begin
            cfg_ff <= nxt_cfg; // [RULE11]
        end
    end

    assign cfg_o = cfg_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic wr_seen_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_seen_ff <= 1'b0;
        end else if (wr_hit) begin
            wr_seen_ff <= 1'b1;
        end
    end

    a_hs_ratio_map: assert property ( // [RULE1]
        (wr_hit && wr_idx == FB_HI_IDX) |=> ##1
        (cfg_o.fb_hs_ratio == {1'b0, $past(req_i.wdata[7:5], 2)} + 4'h4))
        else $error("High-speed ratio does not follow written code");

    a_ls_assembly: assert property ( // [RULE2]
        (wr_hit && wr_idx == FB_MID_IDX) |=> ##1
        (cfg_o.fb_ls[15:8] == $past(req_i.wdata, 2)) &&
        (cfg_o.fb_ls[19:16] == $past(fb_hi_w[3:0], 1)))
        else $error("Low-speed divider bytes misplaced");

    a_fb_reset_vals: assert property ( // [RULE3]
        !wr_seen_ff |-> (fb_hi_w == 8'hC0) && (fb_mid_w == 8'h00) && (fb_lo_w == 8'hF9)
        && (cfg_o.fb_hs_code == 3'h6) && (cfg_o.fb_ls == 20'h000F9))
        else $error("Feedback reset values wrong");

    a_in1_assembly: assert property ( // [RULE4]
        (wr_hit && req_i.addr == 8'h2B) |=> ##1
        (cfg_o.prediv[0][18:16] == $past(req_i.wdata[2:0], 2)))
        else $error("Input 1 upper bits misplaced");

    a_in2_assembly: assert property ( // [RULE5]
        (wr_hit && req_i.addr == 8'h30) |=> ##1
        (cfg_o.prediv[1][7:0] == $past(req_i.wdata, 2)))
        else $error("Input 2 low byte misplaced");

    a_in3_assembly: assert property ( // [RULE6]
        (wr_hit && req_i.addr == 8'h32) |=> ##1
        (cfg_o.prediv[2][15:8] == $past(req_i.wdata, 2)))
        else $error("Input 3 middle byte misplaced");

    a_in4_assembly: assert property ( // [RULE7]
        (wr_hit && req_i.addr == 8'h34) |=> ##1
        (cfg_o.prediv[3][18:16] == $past(req_i.wdata[2:0], 2)))
        else $error("Input 4 upper bits misplaced");

    a_pd_reset_vals: assert property ( // [RULE8]
        !wr_seen_ff |-> (regs_w[5] == 8'h09) && (regs_w[11] == 8'h09)
        && (regs_w[3] == 8'h00) && (regs_w[9] == 8'h00)
        && (cfg_o.prediv[0] == 19'h00009) && (cfg_o.prediv[2] == 19'h00009))
        else $error("Pre-divider reset values wrong");

    a_rsv_read_zero: assert property ( // [RULE9]
        req_i.rd && reg_hit(req_i.addr) && (req_i.addr == 8'h28) |=>
        ack_o && (rdata_o[4] == 1'b0))
        else $error("Reserved feedback bit reads non-zero");

    a_rsv_write_ignored: assert property ( // [RULE10]
        (wr_hit && (req_i.addr == 8'h2B || req_i.addr == 8'h2E)) |=>
        (regs_w[$past(wr_idx)][7:3] == 5'h00) &&
        (regs_w[$past(wr_idx)][2:0] == $past(req_i.wdata[2:0])))
        else $error("Reserved pre-divider bits not ignored");

    a_read_answer: assert property (
        (req_i.rd && !rd_hit) |=> ack_o && (rdata_o == 8'h00))
        else $error("Unmapped read did not return zero");

    a_hs_code_map: assert property ( // [RULE1]
        (wr_hit && wr_idx == FB_HI_IDX) |=> ##1
        (cfg_o.fb_hs_code == $past(req_i.wdata[7:5], 2)))
        else $error("High-speed code not taken from bits 7:5");

    a_hs_ratio_range: assert property ( // [RULE1]
        (cfg_o.fb_hs_ratio == 4'(cfg_o.fb_hs_code) + 4'h4) && (cfg_o.fb_hs_ratio <= 4'hB))
        else $error("High-speed ratio outside 4 to 11");

    a_ls_low_byte: assert property ( // [RULE2]
        (wr_hit && wr_idx == FB_LO_IDX) |=> ##1
        (cfg_o.fb_ls[7:0] == $past(req_i.wdata, 2)))
        else $error("Low-speed divider low byte misplaced");

    a_ls_top_nibble: assert property ( // [RULE2]
        (wr_hit && wr_idx == FB_HI_IDX) |=> ##1
        (cfg_o.fb_ls[19:16] == $past(req_i.wdata[3:0], 2)))
        else $error("Low-speed divider top nibble misplaced");

    a_fb_rsv_write: assert property ( // [RULE10]
        (wr_hit && wr_idx == FB_HI_IDX) |=>
        (fb_hi_w == ($past(req_i.wdata) & 8'hEF)))
        else $error("Reserved feedback bit not ignored");

    a_in1_middle: assert property ( // [RULE4]
        (wr_hit && req_i.addr == IN1_MID_OFS) |=> ##1
        (cfg_o.prediv[0][15:8] == $past(req_i.wdata, 2)))
        else $error("Input 1 middle byte misplaced");

    a_in1_low: assert property ( // [RULE4]
        (wr_hit && req_i.addr == IN1_LO_OFS) |=> ##1
        (cfg_o.prediv[0][7:0] == $past(req_i.wdata, 2)))
        else $error("Input 1 low byte misplaced");

    a_in2_upper: assert property ( // [RULE5]
        (wr_hit && req_i.addr == IN2_HI_OFS) |=> ##1
        (cfg_o.prediv[1][18:16] == $past(req_i.wdata[2:0], 2)))
        else $error("Input 2 upper bits misplaced");

    a_in2_middle: assert property ( // [RULE5]
        (wr_hit && req_i.addr == IN2_MID_OFS) |=> ##1
        (cfg_o.prediv[1][15:8] == $past(req_i.wdata, 2)))
        else $error("Input 2 middle byte misplaced");

    a_in3_upper: assert property ( // [RULE6]
        (wr_hit && req_i.addr == IN3_HI_OFS) |=>
        (regs_w[9][7:3] == 5'h00) ##1
        (cfg_o.prediv[2][18:16] == $past(req_i.wdata[2:0], 2)))
        else $error("Input 3 upper bits misplaced");

    a_in3_low: assert property ( // [RULE6]
        (wr_hit && req_i.addr == IN3_LO_OFS) |=> ##1
        (cfg_o.prediv[2][7:0] == $past(req_i.wdata, 2)))
        else $error("Input 3 low byte misplaced");

    a_in4_middle: assert property ( // [RULE7]
        (wr_hit && req_i.addr == IN4_MID_OFS) |=> ##1
        (cfg_o.prediv[3][15:8] == $past(req_i.wdata, 2)))
        else $error("Input 4 middle byte misplaced");

    a_in4_low: assert property ( // [RULE7]
        (wr_hit && req_i.addr == IN4_LO_OFS) |=> ##1
        (cfg_o.prediv[3][7:0] == $past(req_i.wdata, 2)))
        else $error("Input 4 low byte misplaced");

    a_ack_pulse: assert property (
        req_i.rd |=> ack_o)
        else $error("Read not acknowledged one cycle later");

    a_ack_quiet: assert property (
        !req_i.rd |=> !ack_o)
        else $error("Acknowledge without a read");

    a_rdata_hold: assert property (
        !req_i.rd |=> $stable(rdata_o))
        else $error("Read data changed without a read");

    a_rw_old_value: assert property (
        (req_i.rd && req_i.wr && rd_hit) |=> (rdata_o == $past(regs_w[rd_idx])))
        else $error("Simultaneous read did not return the old value");

    a_unmapped_write: assert property ( // [RULE10]
        (req_i.wr && !rd_hit) |=> $stable(regs_w))
        else $error("Unmapped write changed a register");

    c_fb_full_write: cover property (
        (wr_hit && wr_idx == FB_HI_IDX) ##1 (wr_hit && wr_idx == FB_MID_IDX)
        ##1 (wr_hit && wr_idx == FB_LO_IDX));

    c_prediv_write: cover property (wr_hit && req_i.addr == 8'h36);

    c_read_back: cover property ((wr_hit && wr_idx == FB_LO_IDX) ##1 (req_i.rd && rd_hit));

    c_unmapped: cover property (req_i.wr && !rd_hit);

endmodule

// ---- testbench/pdcr_regs_bench.sv ----
`timescale 1ns/1ps
module pdcr_regs_bench;
    import pdcr_pkg::*;

    logic        clk_i;
    logic        rst_n_i;
    pdcr_req_t   req_i;
    logic        ack_o;
    logic [7:0]  rdata_o;
    pdcr_cfg_t   cfg_o;
    logic [7:0]  mdl [NUM_REGS];
    logic [7:0]  last_rd;
    logic [31:0] seed;
    logic [31:0] r;
    int          n_errors;
    int          tests_run;

    pdcr_regs DUT (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .req_i   (req_i),
        .ack_o   (ack_o),
        .rdata_o (rdata_o),
        .cfg_o   (cfg_o)
    );

    initial clk_i = 1'b0;
    always #10 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] wmask(int i);
        return (i == 0) ? 8'hEF : ((i % 3 == 0) ? 8'h07 : 8'hFF);
    endfunction

    function automatic logic [7:0] rstval(int i);
        case (i)
            0: return 8'hC0;
            2: return 8'hF9;
            5, 11: return 8'h09;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d, comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus cycles, driven at the falling edge
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
                        input logic [7:0] d);
        int         i;
        logic       hit;
        logic [7:0] exp;
        i   = int'(a) - 40;
        hit = (a >= 8'h28) && (a <= 8'h36);
        exp = hit ? mdl[i] : 8'h00;
        req_i = '{wr: wr, rd: rd, addr: a, wdata: d};
        @(negedge clk_i);
        check(ack_o, rd);
        if (rd) begin
            last_rd = exp;
        end
        check(rdata_o, last_rd);
        if (wr && hit) begin
            mdl[i] = d & wmask(i);
        end
    endtask

    task automatic idle();
        req_i = '0;
        @(negedge clk_i);
    endtask

    task automatic chk_cfg();
        check(cfg_o.fb_hs_code, mdl[0][7:5]);
        check(cfg_o.fb_hs_ratio, mdl[0][7:5] + 4);
        check(cfg_o.fb_ls, {mdl[0][3:0], mdl[1], mdl[2]});
        for (int k = 0; k < NUM_INPUTS; k++) begin
            check(cfg_o.prediv[k], {mdl[3*k+3][2:0], mdl[3*k+4], mdl[3*k+5]});
        end
    endtask

    task automatic do_reset();
        rst_n_i = 1'b0;
        req_i   = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            mdl[i] = rstval(i);
        end
        last_rd = 8'h00;
        repeat (3) @(negedge clk_i);
        chk_cfg();
        check(ack_o, 1'b0);
        check(rdata_o, 8'h00);
        rst_n_i = 1'b1;
        @(negedge clk_i);
    endtask

    task automatic read_all();
        for (int i = 0; i < NUM_REGS; i++) begin
            xfer(1'b0, 1'b1, 8'(i) + 8'h28, 8'h00);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed      = 32'h1;
        n_errors  = 0;
        tests_run = 0;
        do_reset();
        read_all();
        xfer(1'b1, 1'b0, 8'h27, 8'hFF);
        xfer(1'b1, 1'b0, 8'h37, 8'hFF);
        xfer(1'b0, 1'b1, 8'h27, 8'h00);
        xfer(1'b0, 1'b1, 8'h37, 8'h00);
        xfer(1'b0, 1'b1, 8'hFF, 8'h00);
        read_all();
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, 1'b0, 8'h28, {3'(c), 5'h1F});
            xfer(1'b0, 1'b1, 8'h28, 8'h00);
            idle();
            chk_cfg();
        end
        // Every byte of each divider written before cfg is judged
        for (int i = 0; i < NUM_REGS; i++) begin
            xfer(1'b1, 1'b0, 8'(i) + 8'h28, 8'hFF);
        end
        read_all();
        idle();
        chk_cfg();
        // Write and read together return the old value
        xfer(1'b1, 1'b1, 8'h2A, 8'h5A);
        xfer(1'b0, 1'b1, 8'h2A, 8'h00);
        repeat (300) begin
            r = xs();
            xfer(r[8], r[9], 8'h26 + 8'(r[7:0] % 8'h13), r[23:16]);
            if (r[12:10] == 3'h0) begin
                idle();
                chk_cfg();
            end
        end
        idle();
        chk_cfg();
        do_reset();
        read_all();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

endmodule
